// ==== inc/dpms_map.svh ====
`ifndef DPMS_MAP_SVH
`define DPMS_MAP_SVH
// ----------------------------------------
// Register word indices on the Avalon-MM slave
// ----------------------------------------
`define DPMS_REG_AFSEL 3'h0
`define DPMS_REG_PUR 3'h1
`define DPMS_REG_DEN 3'h2
`define DPMS_REG_LOCK 3'h3
`define DPMS_REG_COMMIT 3'h4
`define DPMS_REG_STATUS 3'h5
// ----------------------------------------
// Field positions, reset values, keys
// ----------------------------------------
`define DPMS_STAT_DONE_BIT 10
`define DPMS_PIN_RST 4'hf
`define DPMS_PROT_MASK 4'hf
`define DPMS_LOCK_KEY 32'h5a5a_a5a5
`define DPMS_IR_IDCODE 4'he
`define DPMS_IR_CAPTURE 4'h1
// ----------------------------------------
// Switch codes and sequence lengths
// ----------------------------------------
`define DPMS_CODE_J2S 16'he79e
`define DPMS_CODE_S2J 16'he73c
`define DPMS_CODE_BITS 7'h10
`define DPMS_LEAD_CLKS 7'h32
`define DPMS_TRAIL_J2S 7'h32
`define DPMS_TRAIL_S2J 7'h5
`define DPMS_SWITCH_TOTAL 4'ha
// Preamble states, first at the low nibble (TAP state encodings)
`define DPMS_PREAMBLE 64'h0d31_100d_3110_0d31
// ----------------------------------------
// Timing
// ----------------------------------------
`define DPMS_CLK_MHZ 200
`define DPMS_TCK_HALF_NS 40
`define DPMS_TCK_HALF_CYC ((`DPMS_TCK_HALF_NS * `DPMS_CLK_MHZ) / 1000)
`define DPMS_RECOVER_WAIT_MS 400
`define DPMS_RECOVER_WAIT_CYC (`DPMS_RECOVER_WAIT_MS * 1000 * `DPMS_CLK_MHZ)
`define DPMS_ERASE_CYC 16'h3e8
`endif

// ==== inc/dpms_pkg.sv ====
package dpms_pkg;
  // TAP states, Gray coded along the usual path
  typedef enum logic [3:0] {
    TAP_TLR = 4'h0, TAP_RTI = 4'h1, TAP_SEL_DR = 4'h3, TAP_CAP_DR = 4'h2,
    TAP_SH_DR = 4'h6, TAP_EX1_DR = 4'h7, TAP_PA_DR = 4'h5, TAP_EX2_DR = 4'h4,
    TAP_UP_DR = 4'hc, TAP_SEL_IR = 4'hd, TAP_CAP_IR = 4'hf, TAP_SH_IR = 4'he,
    TAP_EX1_IR = 4'ha, TAP_PA_IR = 4'hb, TAP_EX2_IR = 4'h9, TAP_UP_IR = 4'h8
  } dpms_tap_e;
  typedef enum logic {MODE_JTAG = 1'b0, MODE_SWD = 1'b1} dpms_mode_e;
  typedef enum logic [2:0] {
    PRB_IDLE = 3'h0, PRB_LEAD = 3'h1, PRB_CODE = 3'h3, PRB_TRAIL = 3'h2, PRB_WAIT = 3'h6
  } dpms_probe_e;
  typedef enum logic [1:0] {OP_J2S = 2'h0, OP_S2J = 2'h1, OP_RECOVER = 2'h2} dpms_op_e;
  typedef struct packed {
    logic tck_prev;
    dpms_tap_e tap;
    logic [3:0] ir;
    logic [3:0] ir_sh;
    logic byp;
    logic [15:0] hist;
    dpms_mode_e mode;
    logic [3:0] pre_idx;
    logic expect_s2j;
    logic [3:0] rec_cnt;
    logic [15:0] erase_cnt;
    logic erase_on;
    logic nv_restore;
    logic erase_done;
    logic tdo;
    logic tdo_oe;
    logic [3:0] afsel;
    logic [3:0] pur;
    logic [3:0] den;
    logic [3:0] commit;
    logic unlocked;
    logic wreq;
    logic [31:0] rdata;
  } dpms_dev_s;
  typedef struct packed {
    dpms_probe_e st;
    dpms_op_e op;
    logic [3:0] div;
    logic tck;
    logic tms;
    logic [6:0] cnt;
    logic [15:0] word;
    logic [6:0] trail;
    logic rst_pin_b;
    logic [3:0] sent;
    logic [31:0] wait_cnt;
    logic ready;
    logic done;
    logic pwr_cycle;
  } dpms_probe_s;
endpackage

// ==== inc/dpms_link_if.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// Debug link between probe and device
// ----------------------------------------
interface dpms_link_if;
  logic tck;
  logic tms;
  logic tdi;
  logic rst_pin_b;
  logic tdo;
  logic tdo_oe;
  logic tdo_line;
  // Pull-up holds the line high while undriven
  assign tdo_line = tdo_oe ? tdo : 1'b1;
  modport dev(input tck, input tms, input tdi, input rst_pin_b, output tdo, output tdo_oe);
  modport probe(output tck, output tms, output tdi, output rst_pin_b, input tdo_line);
endinterface

// ==== hw/dpms_sync.sv ====
`timescale 1ns/1ps
// Two-flop synchroniser for pin inputs
module dpms_sync #(
  parameter int W = 1
) (
  input logic core_clk,
  input logic rst_b,
  input logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } dpms_sync_s;
  dpms_sync_s st;
  dpms_sync_s next_st;

  // Shift stage one into stage two
  always_comb begin
    next_st.s1 = d;
    next_st.s2 = st.s1;
  end

  // Pins idle high through their pull-ups
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      st <= '1;
    end else begin
      st <= next_st;
    end
  end

  assign q = st.s2;
endmodule

// ==== hw/dpms_dev.sv ====
// Local design decisions: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
`include "dpms_map.svh"
// Overview of operation
// - Reset sets debug pin enables, pull-ups, alt-function
// - Cleared alt-function bits hand pins to GPIO
// - Protected bits change only when unlocked and committed
// - Ten alternating switches under reset erase flash
// - Probe recovers: reset, five pairs, wait, power-cycle
// - Erase finishes before nonvolatile defaults restore
// - Recovery switches may omit trailing ones
// - Preamble walks the TAP through fixed states
// - Preamble enables serial-wire, disables boundary-scan
// - Code e79e, LSB first, enters serial-wire
// - Probe frames e79e with 50 ones each side
// - Code e73c, LSB first, returns to boundary-scan
// - Probe frames e73c with 50 before, 5 after
// - Boundary-scan works only while alt-function set
// - Instruction and data chains only serially reachable
// - Five high mode-select samples reach Test-Logic-Reset
// - Test-Logic-Reset loads identification instruction
module dpms_dev #(
  parameter logic [3:0] PROT_MASK = `DPMS_PROT_MASK,
  parameter logic [15:0] ERASE_CYC = `DPMS_ERASE_CYC
) (
  input logic core_clk,
  input logic rst_b,
  dpms_link_if.dev lnk,
  input logic [2:0] avs_address,
  input logic avs_read,
  input logic avs_write,
  input logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic swd_mode,
  output logic flash_erase,
  output logic nv_restore,
  output logic [3:0] pin_alt_function_select,
  output logic [3:0] pin_pull_up_select,
  output logic [3:0] pin_digital_enable
);
  localparam logic [63:0] PREAMBLE = `DPMS_PREAMBLE;
  // Edge detector starts high like the synchroniser, so no false rise after reset
  localparam dpms_pkg::dpms_dev_s DEV_RST = '{
    tap: dpms_pkg::TAP_TLR, mode: dpms_pkg::MODE_JTAG, ir: `DPMS_IR_IDCODE, hist: 16'hffff,
    afsel: `DPMS_PIN_RST, pur: `DPMS_PIN_RST, den: `DPMS_PIN_RST, wreq: 1'b1, tck_prev: 1'b1, default: '0};

  dpms_pkg::dpms_dev_s st;
  dpms_pkg::dpms_dev_s next_st;
  logic [3:0] pins_s;
  logic [3:0] pin_on;
  logic tck_s;
  logic tms_s;
  logic tdi_s;
  logic ext_rst;
  logic rise;
  logic fall;
  logic req;
  logic sw_j2s;
  logic sw_s2j;
  logic [15:0] hist_n;
  logic [3:0] wmask;
  dpms_pkg::dpms_tap_e tap_n;
  dpms_pkg::dpms_tap_e pre_want;

  // ----------------------------------------
  // TAP next-state function
  // ----------------------------------------
  function automatic dpms_pkg::dpms_tap_e tap_step(input dpms_pkg::dpms_tap_e s, input logic m);
    case (s)
      dpms_pkg::TAP_TLR: return m ? dpms_pkg::TAP_TLR : dpms_pkg::TAP_RTI;
      dpms_pkg::TAP_RTI: return m ? dpms_pkg::TAP_SEL_DR : dpms_pkg::TAP_RTI;
      dpms_pkg::TAP_SEL_DR: return m ? dpms_pkg::TAP_SEL_IR : dpms_pkg::TAP_CAP_DR;
      dpms_pkg::TAP_CAP_DR: return m ? dpms_pkg::TAP_EX1_DR : dpms_pkg::TAP_SH_DR;
      dpms_pkg::TAP_SH_DR: return m ? dpms_pkg::TAP_EX1_DR : dpms_pkg::TAP_SH_DR;
      dpms_pkg::TAP_EX1_DR: return m ? dpms_pkg::TAP_UP_DR : dpms_pkg::TAP_PA_DR;
      dpms_pkg::TAP_PA_DR: return m ? dpms_pkg::TAP_EX2_DR : dpms_pkg::TAP_PA_DR;
      dpms_pkg::TAP_EX2_DR: return m ? dpms_pkg::TAP_UP_DR : dpms_pkg::TAP_SH_DR;
      dpms_pkg::TAP_UP_DR: return m ? dpms_pkg::TAP_SEL_DR : dpms_pkg::TAP_RTI;
      dpms_pkg::TAP_SEL_IR: return m ? dpms_pkg::TAP_TLR : dpms_pkg::TAP_CAP_IR;
      dpms_pkg::TAP_CAP_IR: return m ? dpms_pkg::TAP_EX1_IR : dpms_pkg::TAP_SH_IR;
      dpms_pkg::TAP_SH_IR: return m ? dpms_pkg::TAP_EX1_IR : dpms_pkg::TAP_SH_IR;
      dpms_pkg::TAP_EX1_IR: return m ? dpms_pkg::TAP_UP_IR : dpms_pkg::TAP_PA_IR;
      dpms_pkg::TAP_PA_IR: return m ? dpms_pkg::TAP_EX2_IR : dpms_pkg::TAP_PA_IR;
      dpms_pkg::TAP_EX2_IR: return m ? dpms_pkg::TAP_UP_IR : dpms_pkg::TAP_SH_IR;
      dpms_pkg::TAP_UP_IR: return m ? dpms_pkg::TAP_SEL_DR : dpms_pkg::TAP_RTI;
      default: return dpms_pkg::TAP_TLR;
    endcase
  endfunction

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  dpms_sync #(.W(4)) u_sync (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .d({lnk.rst_pin_b, lnk.tdi, lnk.tms, lnk.tck}),
    .q(pins_s)
  );

  // Clock, mode-select and data-in owned by the debug port only with alt-function and digital enable; reset pin always
  always_comb begin
    pin_on = st.afsel & st.den;
    tck_s = pins_s[0] & pin_on[0];
    tms_s = pins_s[1] | ~pin_on[1];
    tdi_s = pins_s[2] | ~pin_on[2];
    ext_rst = ~pins_s[3];
  end

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    next_st = st;
    next_st.tck_prev = tck_s;
    next_st.nv_restore = 1'b0;
    rise = tck_s & ~st.tck_prev;
    fall = ~tck_s & st.tck_prev;
    req = avs_read | avs_write;
    wmask = ~PROT_MASK | (st.unlocked ? st.commit : 4'h0);
    hist_n = {tms_s, st.hist[15:1]};
    sw_j2s = rise && hist_n == `DPMS_CODE_J2S && st.mode == dpms_pkg::MODE_JTAG;
    sw_s2j = rise && hist_n == `DPMS_CODE_S2J && st.mode == dpms_pkg::MODE_SWD;
    tap_n = tap_step(st.tap, tms_s);
    pre_want = dpms_pkg::dpms_tap_e'(PREAMBLE[{st.pre_idx, 2'b00} +: 4]);

    // TAP and chains step only in boundary-scan mode
    if (rise) begin
      next_st.hist = hist_n;
    end
    if (rise && st.mode == dpms_pkg::MODE_JTAG) begin
      next_st.tap = tap_n;
      // Chains reached by shifting alone, never by the bus
      case (st.tap)
        dpms_pkg::TAP_CAP_IR: next_st.ir_sh = `DPMS_IR_CAPTURE;
        dpms_pkg::TAP_SH_IR: next_st.ir_sh = {tdi_s, st.ir_sh[3:1]};
        dpms_pkg::TAP_UP_IR: next_st.ir = st.ir_sh;
        dpms_pkg::TAP_CAP_DR: next_st.byp = 1'b0;
        dpms_pkg::TAP_SH_DR: next_st.byp = tdi_s;
        default: next_st.byp = st.byp;
      endcase
      if (tap_n == dpms_pkg::TAP_TLR) begin
        next_st.ir = `DPMS_IR_IDCODE;
      end
      // Preamble tracker, must begin from Test-Logic-Reset
      if (tap_n == pre_want && (st.pre_idx != 4'h0 || st.tap == dpms_pkg::TAP_TLR)) begin
        next_st.pre_idx = st.pre_idx + 4'h1;
        if (st.pre_idx == 4'hf) begin
          next_st.mode = dpms_pkg::MODE_SWD;
        end
      end else begin
        next_st.pre_idx = 4'h0;
      end
    end

    // Switch codes move the mode
    if (sw_j2s) begin
      next_st.mode = dpms_pkg::MODE_SWD;
      next_st.hist = 16'hffff;
      next_st.pre_idx = 4'h0;
    end
    if (sw_s2j) begin
      next_st.mode = dpms_pkg::MODE_JTAG;
      next_st.hist = 16'hffff;
      next_st.tap = dpms_pkg::TAP_TLR;
      next_st.ir = `DPMS_IR_IDCODE;
    end

    // Test data out changes on the falling edge, driven only while shifting
    if (fall) begin
      next_st.tdo = (st.tap == dpms_pkg::TAP_SH_IR) ? st.ir_sh[0] : st.byp;
      next_st.tdo_oe = st.tap == dpms_pkg::TAP_SH_IR || st.tap == dpms_pkg::TAP_SH_DR;
    end
    if (!pin_on[3] || st.mode == dpms_pkg::MODE_SWD) begin
      next_st.tdo_oe = 1'b0;
    end

    // ----------------------------------------
    // Avalon-MM slave, one wait cycle per access
    // ----------------------------------------
    next_st.wreq = ~(req & st.wreq);
    if (req && st.wreq) begin
      if (avs_address == `DPMS_REG_AFSEL) begin
        next_st.rdata = {28'h0, st.afsel};
      end else if (avs_address == `DPMS_REG_PUR) begin
        next_st.rdata = {28'h0, st.pur};
      end else if (avs_address == `DPMS_REG_DEN) begin
        next_st.rdata = {28'h0, st.den};
      end else if (avs_address == `DPMS_REG_LOCK) begin
        next_st.rdata = {31'h0, ~st.unlocked};
      end else if (avs_address == `DPMS_REG_COMMIT) begin
        next_st.rdata = {28'h0, st.commit};
      end else if (avs_address == `DPMS_REG_STATUS) begin
        next_st.rdata = {21'h0, st.erase_done, st.erase_on, st.rec_cnt, st.tap, st.mode};
      end else begin
        next_st.rdata = 32'h0;
      end
    end
    if (avs_write && !st.wreq) begin
      if (avs_address == `DPMS_REG_AFSEL) begin
        next_st.afsel = (st.afsel & ~wmask) | (avs_writedata[3:0] & wmask);
      end else if (avs_address == `DPMS_REG_PUR) begin
        next_st.pur = (st.pur & ~wmask) | (avs_writedata[3:0] & wmask);
      end else if (avs_address == `DPMS_REG_DEN) begin
        next_st.den = (st.den & ~wmask) | (avs_writedata[3:0] & wmask);
      end else if (avs_address == `DPMS_REG_LOCK) begin
        next_st.unlocked = avs_writedata == `DPMS_LOCK_KEY;
      end else if (avs_address == `DPMS_REG_COMMIT) begin
        next_st.commit = st.unlocked ? avs_writedata[3:0] : st.commit;
      end else if (avs_address == `DPMS_REG_STATUS) begin
        next_st.erase_done = st.erase_done & ~avs_writedata[`DPMS_STAT_DONE_BIT];
      end
    end

    // External reset returns the pins to debug use
    if (ext_rst) begin
      next_st.afsel = `DPMS_PIN_RST;
      next_st.pur = `DPMS_PIN_RST;
      next_st.den = `DPMS_PIN_RST;
      next_st.commit = 4'h0;
      next_st.unlocked = 1'b0;
    end

    // ----------------------------------------
    // Recovery: count alternating switches under reset
    // ----------------------------------------
    if (st.erase_on) begin
      if (st.erase_cnt == 16'h1) begin
        next_st.erase_on = 1'b0;
        next_st.nv_restore = 1'b1;
        next_st.erase_done = 1'b1;
      end else begin
        next_st.erase_cnt = st.erase_cnt - 16'h1;
      end
    end else if (!ext_rst) begin
      next_st.rec_cnt = 4'h0;
      next_st.expect_s2j = 1'b0;
    end else if ((sw_j2s && !st.expect_s2j) || (sw_s2j && st.expect_s2j)) begin
      next_st.expect_s2j = ~st.expect_s2j;
      if (st.rec_cnt == `DPMS_SWITCH_TOTAL - 4'h1) begin
        next_st.rec_cnt = 4'h0;
        next_st.erase_on = 1'b1;
        next_st.erase_cnt = ERASE_CYC;
      end else begin
        next_st.rec_cnt = st.rec_cnt + 4'h1;
      end
    end
  end

  // State register, boundary-scan mode at power-up
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      st <= DEV_RST;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state register
  assign avs_readdata = st.rdata;
  assign avs_waitrequest = st.wreq;
  assign swd_mode = st.mode;
  assign flash_erase = st.erase_on;
  assign nv_restore = st.nv_restore;
  assign pin_alt_function_select = st.afsel;
  assign pin_pull_up_select = st.pur;
  assign pin_digital_enable = st.den;
  assign lnk.tdo = st.tdo;
  assign lnk.tdo_oe = st.tdo_oe;
endmodule

// ==== hw/dpms_probe.sv ====
`timescale 1ns/1ps
`include "dpms_map.svh"
// Debug probe: makes the test clock and sends switch sequences
module dpms_probe #(
  parameter logic [31:0] WAIT_CYC = 32'(`DPMS_RECOVER_WAIT_CYC),
  parameter logic [3:0] HALF = 4'(`DPMS_TCK_HALF_CYC)
) (
  input logic core_clk,
  input logic rst_b,
  dpms_link_if.probe lnk,
  input logic cmd_valid,
  input dpms_pkg::dpms_op_e cmd_op,
  output logic cmd_ready,
  output logic done,
  output logic power_cycle
);
  localparam dpms_pkg::dpms_probe_s PRB_RST = '{
    st: dpms_pkg::PRB_IDLE, op: dpms_pkg::OP_J2S, rst_pin_b: 1'b1, tms: 1'b1, default: '0};

  dpms_pkg::dpms_probe_s st;
  dpms_pkg::dpms_probe_s next_st;
  logic fin;

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    next_st.pwr_cycle = 1'b0;
    fin = 1'b0;
    case (st.st)
      dpms_pkg::PRB_IDLE: begin
        next_st.ready = 1'b1;
        if (cmd_valid && st.ready) begin
          next_st.ready = 1'b0;
          next_st.op = cmd_op;
          next_st.sent = 4'h0;
          next_st.div = 4'h0;
          next_st.st = dpms_pkg::PRB_LEAD;
          next_st.cnt = `DPMS_LEAD_CLKS;
          next_st.tms = 1'b1;
          next_st.word = (cmd_op == dpms_pkg::OP_S2J) ? `DPMS_CODE_S2J : `DPMS_CODE_J2S;
          if (cmd_op == dpms_pkg::OP_J2S) begin
            next_st.trail = `DPMS_TRAIL_J2S;
          end else if (cmd_op == dpms_pkg::OP_S2J) begin
            next_st.trail = `DPMS_TRAIL_S2J;
          end else begin
            next_st.trail = 7'h0;
          end
          next_st.rst_pin_b = cmd_op != dpms_pkg::OP_RECOVER;
        end
      end
      dpms_pkg::PRB_WAIT: begin
        if (st.wait_cnt == 32'h1) begin
          next_st.pwr_cycle = 1'b1;
          next_st.done = 1'b1;
          next_st.st = dpms_pkg::PRB_IDLE;
        end else begin
          next_st.wait_cnt = st.wait_cnt - 32'h1;
        end
      end
      default: begin
        // Divided clock; data moves on the falling edge
        if (st.div == HALF - 4'h1) begin
          next_st.div = 4'h0;
          next_st.tck = ~st.tck;
          if (st.tck) begin
            case (st.st)
              dpms_pkg::PRB_LEAD: begin
                if (st.cnt == 7'h1) begin
                  next_st.st = dpms_pkg::PRB_CODE;
                  next_st.cnt = `DPMS_CODE_BITS;
                  next_st.tms = st.word[0];
                end else begin
                  next_st.cnt = st.cnt - 7'h1;
                end
              end
              dpms_pkg::PRB_CODE: begin
                next_st.word = {1'b1, st.word[15:1]};
                if (st.cnt == 7'h1) begin
                  next_st.tms = 1'b1;
                  if (st.trail == 7'h0) begin
                    fin = 1'b1;
                  end else begin
                    next_st.st = dpms_pkg::PRB_TRAIL;
                    next_st.cnt = st.trail;
                  end
                end else begin
                  next_st.cnt = st.cnt - 7'h1;
                  next_st.tms = st.word[1];
                end
              end
              default: begin
                if (st.cnt == 7'h1) begin
                  fin = 1'b1;
                end else begin
                  next_st.cnt = st.cnt - 7'h1;
                end
              end
            endcase
          end
        end else begin
          next_st.div = st.div + 4'h1;
        end
        // End of one switch sequence
        if (fin && st.op == dpms_pkg::OP_RECOVER) begin
          next_st.sent = st.sent + 4'h1;
          if (st.sent == `DPMS_SWITCH_TOTAL - 4'h1) begin
            next_st.st = dpms_pkg::PRB_WAIT;
            next_st.rst_pin_b = 1'b1;
            next_st.wait_cnt = WAIT_CYC;
          end else begin
            next_st.st = dpms_pkg::PRB_LEAD;
            next_st.cnt = `DPMS_LEAD_CLKS;
            next_st.word = st.sent[0] ? `DPMS_CODE_J2S : `DPMS_CODE_S2J;
          end
        end else if (fin) begin
          next_st.st = dpms_pkg::PRB_IDLE;
          next_st.done = 1'b1;
        end
      end
    endcase
  end

  // State register
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      st <= PRB_RST;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state register, except tdi, which is tied high
  assign cmd_ready = st.ready;
  assign done = st.done;
  assign power_cycle = st.pwr_cycle;
  assign lnk.tck = st.tck;
  assign lnk.tms = st.tms;
  assign lnk.tdi = 1'b1;
  assign lnk.rst_pin_b = st.rst_pin_b;
endmodule

// ==== tb/dpms_link_asserts.sv ====
`timescale 1ns/1ps
`include "dpms_map.svh"
// ----------------------------------------
// Link protocol checker
// ----------------------------------------
module dpms_link_asserts (
  input logic core_clk,
  input logic rst_b,
  input logic tck,
  input logic tms,
  input logic tdi,
  input logic rst_pin_b,
  input logic tdo,
  input logic tdo_oe,
  input logic tdo_line
);
  logic tck_q;
  logic rise;
  logic [6:0] ones;
  logic [4:0] nb;
  logic [15:0] hist;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // Test clock rise as seen on the pin
  assign rise = tck && !tck_q;
  // Run of ones, code bit count, history LSB first
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      tck_q <= 1'b0;
      ones <= 7'd0;
      nb <= 5'd0;
      hist <= 16'h0;
    end else begin
      tck_q <= tck;
      if (rise) begin
        ones <= tms ? ((ones == 7'd127) ? ones : ones + 7'd1) : 7'd0;
        hist <= {tms, hist[15:1]};
        if (!tms && ones >= 7'd50) nb <= 5'd1;
        else if (nb != 5'd0 && nb < 5'd16) nb <= nb + 5'd1;
        else nb <= 5'd0;
      end
    end
  end
  property p_tms_hold;
    tck |-> $stable(tms);
  endproperty
  a_tms_hold: assert property (p_tms_hold) else $error("tms moved while tck high");
  property p_tck_high;
    $rose(tck) |-> tck [*8];
  endproperty
  a_tck_high: assert property (p_tck_high) else $error("tck high phase short");
  property p_tck_low;
    $fell(tck) |-> !tck [*8];
  endproperty
  a_tck_low: assert property (p_tck_low) else $error("tck low phase short");
  property p_tdi_one;
    tdi;
  endproperty
  a_tdi_one: assert property (p_tdi_one) else $error("tdi not held high");
  property p_pull;
    !tdo_oe |-> tdo_line;
  endproperty
  a_pull: assert property (p_pull) else $error("undriven tdo not pulled high");
  property p_rst_on;
    $fell(rst_pin_b) |-> !tck && tms;
  endproperty
  a_rst_on: assert property (p_rst_on) else $error("reset pin asserted mid clock");
  property p_rst_off;
    $rose(rst_pin_b) |-> !tck;
  endproperty
  a_rst_off: assert property (p_rst_off) else $error("reset pin released with tck high");
  property p_lead;
    rise && !tms && ones > 7'd4 |-> ones >= 7'd50;
  endproperty
  a_lead: assert property (p_lead) else $error("lead run of ones too short");
  property p_code;
    nb == 5'd16 |-> hist == `DPMS_CODE_J2S || hist == `DPMS_CODE_S2J;
  endproperty
  a_code: assert property (p_code) else $error("bad switch code on link");
  c_j2s: cover property (nb == 5'd16 && hist == `DPMS_CODE_J2S);
  c_s2j: cover property (nb == 5'd16 && hist == `DPMS_CODE_S2J);
  c_rec: cover property ($rose(rst_pin_b));
endmodule

// ==== tb/debug_port_mode_switch_test.sv ====
`timescale 1ns/1ps
`include "dpms_map.svh"
module debug_port_mode_switch_test;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [2:0] avs_address = 3'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, q;
  logic avs_waitrequest, cmd_ready, done, power_cycle, swd_mode, flash_erase, nv_restore;
  logic cmd_valid = 1'b0;
  dpms_pkg::dpms_op_e cmd_op = dpms_pkg::OP_J2S;
  logic [3:0] p_af, p_pu, p_de;
  int err_count = 0, compares = 0, cyc = 0, ecnt = 0, ncnt = 0, seed;
  int m_pin [3] = '{15, 15, 15};
  int m_unlk = 0, m_cm = 0, m_mode = 0;
  dpms_link_if link ();
  dpms_dev #(.PROT_MASK(4'hf), .ERASE_CYC(16'h14)) dpms_dev_i (.core_clk(core_clk), .rst_b(rst_b), .lnk(link),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .swd_mode(swd_mode),
    .flash_erase(flash_erase), .nv_restore(nv_restore), .pin_alt_function_select(p_af),
    .pin_pull_up_select(p_pu), .pin_digital_enable(p_de));
  dpms_probe #(.WAIT_CYC(32'h32), .HALF(4'h8)) dpms_probe_i (.core_clk(core_clk), .rst_b(rst_b), .lnk(link),
    .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_ready(cmd_ready), .done(done), .power_cycle(power_cycle));
  dpms_link_asserts dpms_link_asserts_i (.core_clk(core_clk), .rst_b(rst_b), .tck(link.tck), .tms(link.tms),
    .tdi(link.tdi), .rst_pin_b(link.rst_pin_b), .tdo(link.tdo), .tdo_oe(link.tdo_oe), .tdo_line(link.tdo_line));
  // 200 MHz clock
  initial forever #2.5 core_clk = ~core_clk;
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic conclude();
    if (err_count == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      err_count++;
    end
  endtask
  // Avalon-MM access, held until waitrequest sampled low
  task automatic bus(input logic w, input logic [2:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0) @(posedge core_clk);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge core_clk);
  endtask
  // Write with register model update
  task automatic wr(input logic [2:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
    if (a < 3 && m_unlk) m_pin[a] = (d & m_cm) | (m_pin[a] & ~m_cm & 15);
    if (a == 3) m_unlk = (d == `DPMS_LOCK_KEY);
    if (a == 4 && m_unlk) m_cm = d & 15;
  endtask
  task automatic rd(input logic [2:0] a);
    bus(1'b0, a, 32'h0);
    chk($sformatf("reg%0d", a), (a < 3) ? m_pin[a] : (a == 3) ? !m_unlk : 0, q);
  endtask
  // Probe command, then mode against model
  task automatic run(input dpms_pkg::dpms_op_e op);
    while (cmd_ready !== 1'b1) @(posedge core_clk);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    @(posedge core_clk);
    cmd_valid <= 1'b0;
    while (done !== 1'b1) @(posedge core_clk);
    chk("power_cycle", op == dpms_pkg::OP_RECOVER, power_cycle);
    if ((m_pin[0] & m_pin[2]) == 15) m_mode = (op == dpms_pkg::OP_J2S);
    @(posedge core_clk);
    chk("swd_mode", m_mode, swd_mode);
  endtask
  // Erase length, restore pulse, timeout
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (flash_erase === 1'b1) ecnt <= ecnt + 1;
    if (nv_restore === 1'b1) begin
      ncnt <= ncnt + 1;
      chk("erase_len", 20, ecnt);
      chk("erase_off", 0, flash_erase);
    end
    if (cyc == 60000) begin
      err_count++;
      conclude();
    end
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    seed = $urandom(32'h73c4);
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    chk("pins", 12'hfff, {p_af, p_pu, p_de});
    chk("swd_mode", 0, swd_mode);
    for (int a = 0; a < 3; a++) rd(a[2:0]);
    wr(`DPMS_REG_AFSEL, $urandom);
    rd(`DPMS_REG_AFSEL);
    wr(`DPMS_REG_LOCK, `DPMS_LOCK_KEY);
    wr(`DPMS_REG_COMMIT, 32'hf);
    wr(`DPMS_REG_AFSEL, 32'h0);
    rd(`DPMS_REG_AFSEL);
    run(dpms_pkg::OP_J2S);
    chk("pin_af", 0, p_af);
    wr(`DPMS_REG_AFSEL, 32'hf);
    wr(`DPMS_REG_LOCK, $urandom & 32'hfff0);
    rd(`DPMS_REG_LOCK);
    wr(`DPMS_REG_PUR, 32'h0);
    rd(`DPMS_REG_PUR);
    rd(3'h6 + 3'($urandom % 2));
    run(dpms_pkg::OP_J2S);
    chk("pin_af", 15, p_af);
    run(dpms_pkg::OP_J2S);
    run(dpms_pkg::OP_S2J);
    run(dpms_pkg::OP_S2J);
    bus(1'b0, `DPMS_REG_STATUS, 32'h0);
    chk("tap", 0, q[4:1]);
    chk("erase", 0, ecnt);
    run(dpms_pkg::OP_RECOVER);
    m_pin = '{15, 15, 15};
    m_unlk = 0;
    m_cm = 0;
    chk("erase", 20, ecnt);
    chk("nv_pulses", 1, ncnt);
    bus(1'b0, `DPMS_REG_STATUS, 32'h0);
    chk("erase_done", 1, q[`DPMS_STAT_DONE_BIT]);
    // Done flag clears on a write of one
    bus(1'b1, `DPMS_REG_STATUS, 32'h1 << `DPMS_STAT_DONE_BIT);
    bus(1'b0, `DPMS_REG_STATUS, 32'h0);
    chk("erase_clr", 0, q[`DPMS_STAT_DONE_BIT]);
    rd(`DPMS_REG_AFSEL);
    rd(`DPMS_REG_LOCK);
    conclude();
  end
endmodule
